// ### src/sp_pkg.sv
package sp_pkg;
  localparam int SP_CLK_HZ = 100_000_000;
  localparam int SP_MAX_SCK_HZ = 12_500_000;
  // Smallest divider that keeps the master bit rate at or below the limit.
  localparam logic [7:0] SP_MIN_DIV =
    8'(SP_CLK_HZ / (2 * SP_MAX_SCK_HZ) - 1);
  localparam int SP_DATA_W = 8;
  localparam int SP_FIFO_DEPTH = 16;
  localparam int SP_IDX_W = 4;
  localparam logic [SP_IDX_W-1:0] SP_IDX_FIRST = 4'h0;
  localparam logic [SP_IDX_W-1:0] SP_IDX_LAST = 4'hf;
  localparam logic [7:0] SP_BYTE_RST = 8'h00;
  localparam logic [1:0] SP_MODE_3WIRE = 2'h0;
  localparam logic [1:0] SP_MODE_MULTI = 2'h1;
  localparam int SP_F_DONE = 0;
  localparam int SP_F_WRITE_COLLISION_FLAG = 1;
  localparam int SP_F_MODE_FAULT_FLAG = 2;
  localparam int SP_F_OVRN = 3;
  localparam logic [3:0] SP_FLAGS_RST = 4'h0;

  typedef struct packed {
    logic [7:0] clk_div;
    logic master_enable;
    logic port_enable;
    logic clock_phase;
    logic clock_polarity;
    logic [1:0] select_mode;
  } sp_cfg_t;

  typedef struct packed {
    logic busy;
    logic tx_empty;
    logic sr_empty;
    logic rx_empty;
    logic slave_selected;
    logic select_pin;
    logic [3:0] flags;
  } sp_status_t;

  localparam sp_cfg_t SP_CFG_RST = '{clk_div: 8'h00, master_enable: 1'b0,
    port_enable: 1'b0, clock_phase: 1'b0, clock_polarity: 1'b0,
    select_mode: 2'h1};
endpackage

// ### src/sp_fifo.sv
`timescale 1ns/1ps
module sp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic out_valid_r;
  logic [W-1:0] out_data_r;
  wire empty = (wp_r == rp_r);
  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire push = in_valid & ~full;
  // The output register refills whenever it is empty or being taken.
  wire pop = ~empty & (~out_valid_r | out_ready);

  assign in_ready = ~full;
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
        out_data_r <= mem_r[rp_r[AW-1:0]];
        out_valid_r <= 1'b1;
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
    end
  end
endmodule

// ### src/sp_port.sv
`timescale 1ns/1ps
module sp_port (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cfg_wr,
  input wire sp_pkg::sp_cfg_t cfg_wdata,
  output sp_pkg::sp_cfg_t cfg,
  input wire logic [3:0] flag_clr,
  input wire logic irq_enable,
  output logic irq,
  output sp_pkg::sp_status_t status,
  input wire logic dat_wr,
  input wire logic [7:0] dat_wdata,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic nss_in,
  output logic nss_out,
  output logic nss_oe
);
  sp_pkg::sp_cfg_t cfg_r;
  sp_pkg::sp_cfg_t cfg_nxt;
  logic [3:0] flag_r;
  logic [3:0] flag_nxt;
  logic [1:0] sck_q;
  logic [1:0] mosi_q;
  logic [1:0] miso_q;
  logic [1:0] nss_q;
  logic sck_d_r;
  logic nss_d_r;
  logic [7:0] sh_r;
  logic [7:0] txb_r;
  logic [7:0] rxb_r;
  logic txb_full_r;
  logic sr_full_r;
  logic rxb_full_r;
  logic busy_r;
  logic sck_r;
  logic rbit_r;
  logic [7:0] div_cnt_r;
  logic [sp_pkg::SP_IDX_W-1:0] idx_r;
  logic fifo_in_ready;

  wire sck_s = sck_q[1];
  wire mosi_s = mosi_q[1];
  wire miso_s = miso_q[1];
  wire nss_s = nss_q[1];
  wire master = cfg_r.master_enable;
  wire pen = cfg_r.port_enable;
  wire cpha = cfg_r.clock_phase;
  wire cpol = cfg_r.clock_polarity;
  wire mode_multi = (cfg_r.select_mode == sp_pkg::SP_MODE_MULTI);
  wire mode_3w = (cfg_r.select_mode == sp_pkg::SP_MODE_3WIRE);
  // Only the multi-master/4-wire mode listens to the select pin.
  wire selected = ~mode_multi | ~nss_s;
  wire fault = pen & master & mode_multi & ~nss_s;
  wire nss_fall = nss_d_r & ~nss_s;
  wire active_s = pen & ~master & selected;

  // Half period is divider plus one cycles, clamped to the rate limit.
  wire [7:0] div_eff = (cfg_r.clk_div < sp_pkg::SP_MIN_DIV) ?
    sp_pkg::SP_MIN_DIV : cfg_r.clk_div;
  wire tick = busy_r & (div_cnt_r == div_eff);

  wire s_edge = active_s & (sck_s != sck_d_r);
  wire edge_ev = master ? (pen & tick) : s_edge;
  wire bit_in = master ? miso_s : mosi_s;
  // Even edges latch with phase 0, odd edges with phase 1.
  wire samp = (idx_r[0] == cpha);
  wire last = (idx_r == sp_pkg::SP_IDX_LAST);
  wire skip0 = cpha & (idx_r == sp_pkg::SP_IDX_FIRST);
  wire done = edge_ev & last;
  wire do_shift = edge_ev & (samp ? (cpha & last) : ~skip0);
  wire [7:0] sh_in = {sh_r[6:0], (samp ? bit_in : rbit_r)};
  wire idle_sr = ~sr_full_r & ~busy_r &
    (idx_r == sp_pkg::SP_IDX_FIRST);
  wire load = pen & txb_full_r & idle_sr;
  wire write_collision_flag_ev = dat_wr & txb_full_r;
  wire tx_acc = dat_wr & ~txb_full_r;
  // A buffer that passes into the FIFO in this cycle counts as read.
  wire rx_busy = rxb_full_r & ~fifo_in_ready;
  wire rx_take = done & (master | ~rx_busy);
  wire ovr_ev = done & ~master & rx_busy;
  wire drain = rxb_full_r & fifo_in_ready;
  wire idx_clr = ~pen | fault | (~master & mode_multi & nss_fall);
  wire [3:0] flag_set = {ovr_ev, fault, write_collision_flag_ev, done};

  always_comb begin
    cfg_nxt = cfg_wr ? cfg_wdata : cfg_r;
    if (fault) begin
      cfg_nxt.master_enable = 1'b0;
      cfg_nxt.port_enable = 1'b0;
    end
  end

  // Set wins over a clear in the same cycle.
  assign flag_nxt = flag_set | (flag_r & ~flag_clr);

  assign cfg = cfg_r;
  assign irq = irq_enable & (|flag_r);
  assign sck_out = sck_r;
  assign sck_oe = pen & master;
  assign mosi_out = sh_r[7];
  assign mosi_oe = pen & master;
  assign miso_out = sh_r[7];
  assign miso_oe = pen & ~master & selected;
  assign nss_out = cfg_r.select_mode[0];
  assign nss_oe = cfg_r.select_mode[1];
  assign status = '{busy: busy_r | (active_s & ~idle_sr),
    tx_empty: ~txb_full_r, sr_empty: ~sr_full_r, rx_empty: ~rxb_full_r,
    slave_selected: ~nss_s & ~mode_3w, select_pin: nss_s, flags: flag_r};

  // Pin inputs cross into the clock domain through two flip-flops.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sck_q <= 2'h0;
      mosi_q <= 2'h0;
      miso_q <= 2'h0;
      nss_q <= 2'h3;
      sck_d_r <= 1'b0;
      nss_d_r <= 1'b1;
    end else begin
      sck_q <= {sck_q[0], sck_in};
      mosi_q <= {mosi_q[0], mosi_in};
      miso_q <= {miso_q[0], miso_in};
      nss_q <= {nss_q[0], nss_in};
      sck_d_r <= sck_s;
      nss_d_r <= nss_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_r <= sp_pkg::SP_CFG_RST;
      flag_r <= sp_pkg::SP_FLAGS_RST;
    end else begin
      cfg_r <= cfg_nxt;
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txb_r <= sp_pkg::SP_BYTE_RST;
      txb_full_r <= 1'b0;
    end else begin
      if (tx_acc) begin
        txb_r <= dat_wdata;
      end
      txb_full_r <= tx_acc | (txb_full_r & ~load);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sh_r <= sp_pkg::SP_BYTE_RST;
      sr_full_r <= 1'b0;
      rbit_r <= 1'b0;
    end else begin
      if (load) begin
        sh_r <= txb_r;
      end else if (do_shift) begin
        sh_r <= sh_in;
      end
      // A disable or a mode fault cuts the byte and frees the register.
      sr_full_r <= load | (sr_full_r & ~done & pen & ~fault);
      if (edge_ev & samp) begin
        rbit_r <= bit_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      idx_r <= sp_pkg::SP_IDX_FIRST;
    end else if (idx_clr) begin
      idx_r <= sp_pkg::SP_IDX_FIRST;
    end else if (edge_ev) begin
      idx_r <= idx_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      div_cnt_r <= 8'h00;
      sck_r <= 1'b0;
    end else begin
      if (~pen | fault | ~master | done) begin
        busy_r <= 1'b0;
      end else if (load) begin
        busy_r <= 1'b1;
      end
      div_cnt_r <= (~busy_r | tick) ? 8'h00 : div_cnt_r + 1'b1;
      if (~busy_r) begin
        sck_r <= cpol;
      end else if (tick) begin
        sck_r <= ~sck_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxb_r <= sp_pkg::SP_BYTE_RST;
      rxb_full_r <= 1'b0;
    end else begin
      if (rx_take) begin
        rxb_r <= sh_in;
      end
      rxb_full_r <= rx_take | (rxb_full_r & ~drain);
    end
  end

  sp_fifo #(.W(sp_pkg::SP_DATA_W), .DEPTH(sp_pkg::SP_FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(rxb_full_r),
    .in_ready(fifo_in_ready),
    .in_data(rxb_r),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_write_collision_flag;
    dat_wr && txb_full_r |=> flag_r[sp_pkg::SP_F_WRITE_COLLISION_FLAG] && $stable(txb_r);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

  property p_done;
    done |=> flag_r[sp_pkg::SP_F_DONE] && !sr_full_r;
  endproperty
  a_done: assert property (p_done) else $error("done flag missed");

  property p_mode_fault_flag;
    pen && master && mode_multi && !nss_s |=>
      !cfg_r.master_enable && !cfg_r.port_enable &&
      flag_r[sp_pkg::SP_F_MODE_FAULT_FLAG];
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault missed");

  property p_nss_out;
    cfg_r.select_mode[1] |-> nss_oe && (nss_out == cfg_r.select_mode[0]);
  endproperty
  a_nss_out: assert property (p_nss_out) else $error("select out wrong");

  property p_miso_z;
    !pen || (!master && mode_multi && nss_s) |-> !miso_oe;
  endproperty
  a_miso_z: assert property (p_miso_z) else $error("miso driven");

  property p_ovrn;
    ovr_ev |=> flag_r[sp_pkg::SP_F_OVRN] && rxb_full_r &&
      (rxb_r == $past(rxb_r));
  endproperty
  a_ovrn: assert property (p_ovrn) else $error("overrun wrong");

  property p_sticky;
    flag_r[sp_pkg::SP_F_DONE] && !flag_clr[sp_pkg::SP_F_DONE] |=>
      flag_r[sp_pkg::SP_F_DONE];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_start;
    load && master && pen && !fault |=> busy_r ##1 (sck_out == $past(cpol));
  endproperty
  a_start: assert property (p_start) else $error("no start");

  property p_slave_quiet;
    !master |-> !sck_oe ##1 !busy_r;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave busy");

  // The toggle itself shows one cycle after the tick.
  property p_half;
    busy_r && tick && (div_eff == sp_pkg::SP_MIN_DIV) && $stable(cfg_r) |->
      ##2 $stable(sck_out)[*3];
  endproperty
  a_half: assert property (p_half) else $error("sck too fast");

  c_master: cover property (master && done);
  c_slave: cover property (!master && done);
  c_ovrn: cover property (ovr_ev);
  c_mode_fault_flag: cover property (fault);
endmodule

// ### verification/sp_peer.sv
`timescale 1ns/1ps
module sp_peer (
  input wire logic clk,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_out,
  input wire logic mosi_oe,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic nss_out,
  input wire logic nss_oe,
  output logic sck_l,
  output logic mosi_l,
  output logic miso_l,
  output logic nss_l
);
  logic m_sck = 1'b0;
  logic m_mosi = 1'b0;
  logic m_nss = 1'b1;
  logic s_miso = 1'b0;
  logic mosi_h = 1'b0;
  logic pha = 1'b0;
  logic [7:0] s_tx = 8'h00;
  logic [7:0] s_rx = 8'h00;
  logic [7:0] q_rx[$];
  int e = 0;
  int b = 0;
  assign sck_l = sck_oe ? sck_out : m_sck;
  assign mosi_l = mosi_oe ? mosi_out : m_mosi;
  assign miso_l = miso_oe ? miso_out : s_miso;
  assign nss_l = nss_oe ? nss_out : m_nss;

  task automatic arm(input logic [7:0] tx, input logic p);
    s_tx = tx;
    pha = p;
    e = 0;
    s_miso = tx[7];
    q_rx.delete();
  endtask

  // A real slave latches the level that stood just before the clock edge.
  always @(negedge clk) mosi_h = mosi_out;

  // Slave side: bytes repeat back to back, so the bit index wraps at 8.
  always @(sck_out) begin
    if (sck_oe) begin
      b = e % 16;
      e = e + 1;
      if (b % 2 == int'(pha)) begin
        s_rx = {s_rx[6:0], mosi_h};
        if (b >= 14) q_rx.push_back(s_rx);
      end else begin
        s_miso = s_tx[7 - ((b + 1) / 2) % 8];
      end
    end
  end

  task automatic xfer(input logic [7:0] tx, input logic p, input int n,
    output logic [7:0] rx);
    m_nss = 1'b0;
    m_mosi = tx[7];
    repeat (6) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      if (i % 2 == int'(p)) rx = {rx[6:0], miso_l};
      m_sck = ~m_sck;
      if (i % 2 != int'(p)) m_mosi = tx[7 - ((i + 1) / 2) % 8];
      repeat (5) @(negedge clk);
    end
    m_nss = 1'b1;
    m_mosi = ~m_mosi;
    repeat (6) @(negedge clk);
  endtask
endmodule

// ### verification/tb_sp_port.sv
`timescale 1ns/1ps
module tb_sp_port;
  logic clk = 1'b0;
  logic reset_n, cfg_wr, irq_enable, irq, dat_wr, rd_valid, rd_ready;
  sp_pkg::sp_cfg_t cfg_wdata;
  sp_pkg::sp_cfg_t cfg;
  sp_pkg::sp_status_t status;
  logic [3:0] flag_clr;
  logic [7:0] dat_wdata, rd_data, x;
  logic sck_l, mosi_l, miso_l, nss_l, sck_q;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic nss_out, nss_oe;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int cnt = 0;
  int gap = 0;
  always #5 clk = ~clk;

  sp_port i_dut (.clk, .reset_n, .cfg_wr, .cfg_wdata, .cfg, .flag_clr,
    .irq_enable, .irq, .status, .dat_wr, .dat_wdata, .rd_valid, .rd_ready,
    .rd_data, .sck_in(sck_l), .sck_out, .sck_oe, .mosi_in(mosi_l),
    .mosi_out, .mosi_oe, .miso_in(miso_l), .miso_out, .miso_oe,
    .nss_in(nss_l), .nss_out, .nss_oe);
  sp_peer i_peer (.clk, .sck_out, .sck_oe, .mosi_out, .mosi_oe, .miso_out,
    .miso_oe, .nss_out, .nss_oe, .sck_l, .mosi_l, .miso_l, .nss_l);

  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Every config change passes through a disabled state first.
  task automatic setc(input logic [7:0] d, input logic m, input logic ph,
    input logic po, input logic [1:0] sm);
    for (int e = 0; e < 2; e++) begin
      @(negedge clk);
      cfg_wr = 1'b1;
      cfg_wdata = '{d, m, e[0], ph, po, sm};
    end
    @(negedge clk);
    cfg_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] b);
    @(negedge clk);
    dat_wr = 1'b1;
    dat_wdata = b;
    @(negedge clk);
    dat_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] exp);
    int i = 0;
    while (rd_valid !== 1'b1 && i < 50) begin
      @(negedge clk);
      i++;
    end
    chk(rd_data, exp);
    rd_ready = 1'b1;
    @(negedge clk);
    rd_ready = 1'b0;
  endtask

  task automatic clr();
    flag_clr = 4'hf;
    @(negedge clk);
    flag_clr = 4'h0;
    @(negedge clk);
  endtask

  task automatic waitq(input int n);
    for (int i = 0; i < 400 && i_peer.q_rx.size() < n; i++) @(negedge clk);
    repeat (6) @(negedge clk);
  endtask

  // Measures the spacing of the last two clock toggles, and cuts hangs.
  always @(negedge clk) begin
    cyc++;
    cnt++;
    if (sck_out !== sck_q) begin
      gap = cnt;
      cnt = 0;
    end
    sck_q = sck_out;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    reset_n = 1'b0;
    cfg_wr = 1'b0;
    cfg_wdata = sp_pkg::SP_CFG_RST;
    flag_clr = 4'h0;
    irq_enable = 1'b1;
    dat_wr = 1'b0;
    dat_wdata = 8'h00;
    rd_ready = 1'b0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk(cfg, sp_pkg::SP_CFG_RST);
    chk({status.tx_empty, status.flags}, 5'h10);
    chk({miso_oe, nss_oe, irq}, 3'h0);
    chk({sck_oe, mosi_oe}, 2'h0);
    for (int m = 0; m < 4; m++) begin
      setc((m < 3) ? 8'h04 : 8'h00, 1'b1, m[0], m[1], 2'h0);
      chk(sck_out, m[1]);
      chk(nss_oe, 1'b0);
      i_peer.arm(8'h3c ^ 8'(m), m[0]);
      wr(8'ha5 + 8'(m));
      @(negedge clk);
      wr(8'h5a);
      wr(8'hff);
      waitq(2);
      chk(i_peer.q_rx[0], 8'ha5 + 8'(m));
      chk(i_peer.q_rx[1], 8'h5a);
      chk(status.flags, 4'h3);
      chk(irq, 1'b1);
      chk(16'(gap), (m < 3) ? 16'h5 : 16'h4);
      rd(8'h3c ^ 8'(m));
      rd(8'h3c ^ 8'(m));
      irq_enable = 1'b0;
      repeat (2) @(negedge clk);
      chk(irq, 1'b0);
      irq_enable = 1'b1;
      clr();
      chk(status.flags, 4'h0);
    end
    setc(8'h04, 1'b1, 1'b0, 1'b0, 2'h1);
    i_peer.m_nss = 1'b0;
    repeat (6) @(negedge clk);
    chk({cfg.master_enable, cfg.port_enable}, 2'h0);
    chk(status.flags, 4'h4);
    i_peer.m_nss = 1'b1;
    clr();
    for (int s = 2; s < 4; s++) begin
      setc(8'h04, 1'b1, 1'b0, 1'b0, 2'(s));
      chk({nss_oe, nss_out}, {1'b1, s[0]});
    end
    setc(8'h00, 1'b0, 1'b1, 1'b0, 2'h1);
    chk(miso_oe, 1'b0);
    wr(8'hc3);
    repeat (20) @(negedge clk);
    chk({sck_oe, status.busy}, 2'h0);
    chk({status.sr_empty, status.rx_empty, status.slave_selected,
      status.select_pin}, 4'h5);
    i_peer.xfer(8'h96, 1'b1, 16, x);
    chk(x, 8'hc3);
    chk(status.flags, 4'h1);
    rd(8'h96);
    i_peer.xfer(8'h00, 1'b1, 6, x);
    i_peer.xfer(8'h69, 1'b1, 16, x);
    rd(8'h69);
    clr();
    for (int i = 0; i < 19; i++) i_peer.xfer(8'(i), 1'b1, 16, x);
    chk(status.flags, 4'h9);
    for (int i = 0; i < 18; i++) rd(8'(i));
    chk(rd_valid, 1'b0);
    setc(8'h00, 1'b0, 1'b0, 1'b0, 2'h0);
    i_peer.xfer(8'h00, 1'b0, 6, x);
    setc(8'h00, 1'b0, 1'b0, 1'b0, 2'h0);
    i_peer.xfer(8'h81, 1'b0, 16, x);
    rd(8'h81);
    end_sim();
  end
endmodule
